// ---- logic/hgs_pkg.sv ----
// What this block does
// - Pull chop indicator low during internal chop brake
// - Regulation disabled keeps chop indicator released
// - Input-commanded slow decay never pulls indicator low
// - Drive keeps indicator released; brake end resumes
// - Flag overcurrent when sense comparator exceeds limit
// - Grounded sense inputs also disable current regulation
// - Five source levels, sink about twice source
// - Strap grounded selects 6 / 12.5 mA, monitor on
// - Strap open selects 100 / 200 mA, monitor on
// - Strap at rail: 25 / 50 mA, monitor off
// - Middle strap levels decode with monitor on
// - Peak current for drive window, then hold
// - Strong low-side pull-down during high-side turn-on
// - Opposite FET off before a FET turns on
// - Digital dead interval of about 150 ns
// - Deglitch bridge inputs before acting on them
// - Ramp down conducting gate before driving new one
// - Chop threshold brakes low side until off-time ends
// - Ignore chop comparator during blanking after enable
//
// Purpose: Shared types and constants of the H-bridge gate drive sequencer.
// Assumes: 100 MHz clock; sleep acts as the asynchronous reset.
// Notes: Currents are in tenths of a milliampere.
package hgs_pkg;
	localparam int CLK_NS = 10;
	localparam int DEAD_NS = 150;
	localparam int CNT_W = 12;
	localparam int IN_W = 2;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 2;

	// Drive currents, tenths of mA
	localparam logic [11:0] I_6MA = 12'h03C;
	localparam logic [11:0] I_12P5MA = 12'h07D;
	localparam logic [11:0] I_25MA = 12'h0FA;
	localparam logic [11:0] I_50MA = 12'h1F4;
	localparam logic [11:0] I_100MA = 12'h3E8;
	localparam logic [11:0] I_150MA = 12'h5DC;
	localparam logic [11:0] I_200MA = 12'h7D0;
	localparam logic [11:0] I_300MA = 12'hBB8;

	// Register map
	localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 2'h1;
	localparam int CTRL_REG_EN_BIT = 0;
	localparam int CTRL_PWM_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam int ST_OC_BIT = 0;
	localparam int ST_CHOP_BIT = 1;
	localparam int ST_HS_PROT_BIT = 2;
	localparam int ST_STRAP_LSB = 4;

	typedef enum logic [2:0] {
		STRAP_GND = 3'h0,
		STRAP_0V7 = 3'h1,
		STRAP_2V = 3'h2,
		STRAP_OPEN = 3'h3,
		STRAP_4V = 3'h4,
		STRAP_RAIL = 3'h5
	} hgs_strap_t;

	typedef enum logic [1:0] {
		LEG_NONE = 2'h0,
		LEG_HIGH = 2'h1,
		LEG_LOW = 2'h2
	} hgs_leg_t;

	// Gray order along idle, ramp off, dead, peak on
	typedef enum logic [1:0] {
		HB_IDLE = 2'h0,
		HB_RAMP_OFF = 2'h1,
		HB_DEAD = 2'h3,
		HB_PEAK_ON = 2'h2
	} hgs_hb_phase_t;

	// Gray order along idle, blank, armed, off-time
	typedef enum logic [1:0] {
		CH_IDLE = 2'h0,
		CH_BLANK = 2'h1,
		CH_ARMED = 2'h3,
		CH_OFF = 2'h2
	} hgs_chop_t;

	typedef struct packed {
		hgs_hb_phase_t phase;
		hgs_leg_t leg;
		hgs_leg_t goal;
		logic [CNT_W-1:0] cnt;
	} hgs_hb_t;

	typedef struct packed {
		logic high_on;
		logic low_on;
		logic peak;
		logic low_strong;
	} hgs_gate_t;

	typedef struct packed {
		logic [11:0] src;
		logic [11:0] snk;
		logic hs_prot_en;
	} hgs_drive_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic we;
		logic re;
	} hgs_bus_t;

	typedef struct packed {
		logic [IN_W-1:0] q;
		logic [IN_W-1:0] last;
		logic [CNT_W-1:0] cnt;
	} hgs_dg_t;

	typedef struct packed {
		hgs_hb_t hb_a;
		hgs_hb_t hb_b;
		hgs_gate_t gate_a;
		hgs_gate_t gate_b;
		hgs_chop_t chop;
		logic [CNT_W-1:0] cnt;
		logic prev_dir;
		logic [1:0] ctrl;
		logic oc_sticky;
		logic oc_level;
		hgs_strap_t strap;
		logic strap_loaded;
		hgs_drive_t drive;
		logic chop_oe;
		logic chop_o;
		logic [DATA_W-1:0] rdata;
	} hgs_state_t;

	// Strap decode; unused codes fall back to the open setting
	function automatic hgs_drive_t strap_decode(input hgs_strap_t code);
		hgs_drive_t d;
		case (code)
			STRAP_GND: d = '{I_6MA, I_12P5MA, 1'b1};
			STRAP_0V7: d = '{I_12P5MA, I_25MA, 1'b1};
			STRAP_2V: d = '{I_25MA, I_50MA, 1'b1};
			STRAP_OPEN: d = '{I_100MA, I_200MA, 1'b1};
			STRAP_4V: d = '{I_150MA, I_300MA, 1'b1};
			STRAP_RAIL: d = '{I_25MA, I_50MA, 1'b0};
			default: d = '{I_100MA, I_200MA, 1'b1};
		endcase
		return d;
	endfunction
endpackage

// ---- logic/hgs_deglitch.sv ----
// Purpose: Deglitch filter for the bridge control inputs.
// Assumes: Inputs are synchronous to i_clk.
// Notes: The output follows only a value held for HOLD_CYC cycles.
`timescale 1ns/1ps
module hgs_deglitch
#(
	parameter int HOLD_CYC = 40
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [hgs_pkg::IN_W-1:0] i_d,
	output logic [hgs_pkg::IN_W-1:0] o_q
);
	import hgs_pkg::*;

	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

	hgs_dg_t s;
	hgs_dg_t next_s;

	// Any change restarts the stability count, so short pulses die here
	always_comb
	begin
		next_s = s;
		if (i_d != s.last)
		begin
			next_s.last = i_d;
			next_s.cnt = '0;
		end
		else if (s.last != s.q)
		begin
			if (s.cnt >= HOLD_LAST)
				next_s.q = s.last;
			else
				next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign o_q = s.q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	a_glitch_blocked: assert property ($changed(o_q) |-> $past(s.last) == o_q)
		else $error("deglitch output took an unsettled value");
endmodule // hgs_deglitch

// ---- logic/hgs_sequencer.sv ----
// Purpose: Gate drive sequencer for one H-bridge of four N-channel FETs.
// Assumes: Inputs synchronous to i_clk; i_arst_n low while asleep.
// Notes: Analog sensing arrives as comparator levels; strap as a code.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module hgs_sequencer
#(
	parameter int T_DRIVE_NS = 2000,
	parameter int T_OFF_NS = 25000,
	parameter int T_BLANK_NS = 2000,
	parameter int T_GLITCH_NS = 400
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_bridge_in_a,
	input wire logic i_bridge_in_b,
	input wire logic chop_current_threshold_over,
	input wire logic i_sense_over,
	input wire logic i_sense_grounded,
	input wire hgs_pkg::hgs_strap_t i_strap_code,
	input wire hgs_pkg::hgs_bus_t i_bus,
	output hgs_pkg::hgs_gate_t o_gate_a,
	output hgs_pkg::hgs_gate_t o_gate_b,
	output hgs_pkg::hgs_drive_t o_drive,
	output logic o_chop_indicator_n_o,
	output logic o_chop_indicator_n_oe,
	output logic o_overcurrent,
	output logic [hgs_pkg::DATA_W-1:0] o_rdata
);
	import hgs_pkg::*;

	localparam int DRIVE_CYC = (T_DRIVE_NS + CLK_NS - 1) / CLK_NS;
	localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int OFF_CYC = T_OFF_NS / CLK_NS;
	localparam int BLANK_CYC = (T_BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int GLITCH_CYC = (T_GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [CNT_W-1:0] DRIVE_LAST = CNT_W'(DRIVE_CYC - 1);
	localparam logic [CNT_W-1:0] DEAD_LAST = CNT_W'(DEAD_CYC - 1);
	localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(OFF_CYC - 1);
	localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYC - 1);

	hgs_state_t s;
	hgs_state_t next_s;
	logic [IN_W-1:0] filt;
	logic fwd;
	logic rev;
	logic brake_in;
	logic drive_cmd;
	logic reg_en;
	logic oc_clear;
	hgs_leg_t want_a;
	hgs_leg_t want_b;

	// One half-bridge step: off, ramp down, dead time, peak on, hold
	function automatic hgs_hb_t hb_step(input hgs_hb_t cur, input hgs_leg_t want);
		hgs_hb_t n;
		n = cur;
		case (cur.phase)
			HB_IDLE:
			begin
				if (want != cur.leg)
				begin
					n.goal = want;
					n.leg = LEG_NONE;
					if (cur.leg != LEG_NONE)
					begin
						n.phase = HB_RAMP_OFF;
						n.cnt = DRIVE_LAST;
					end
					else
					begin
						n.phase = HB_DEAD;
						n.cnt = DEAD_LAST;
					end
				end
			end
			HB_RAMP_OFF:
			begin
				if (cur.cnt == '0)
				begin
					n.phase = HB_DEAD;
					n.cnt = DEAD_LAST;
				end
				else
					n.cnt = cur.cnt - 1'b1;
			end
			HB_DEAD:
			begin
				if (cur.cnt != '0)
					n.cnt = cur.cnt - 1'b1;
				else if (cur.goal == LEG_NONE)
					n.phase = HB_IDLE;
				else
				begin
					n.phase = HB_PEAK_ON;
					n.leg = cur.goal;
					n.cnt = DRIVE_LAST;
				end
			end
			HB_PEAK_ON:
			begin
				if (cur.cnt == '0)
					n.phase = HB_IDLE;
				else
					n.cnt = cur.cnt - 1'b1;
			end
			default: n = '{HB_IDLE, LEG_NONE, LEG_NONE, '0};
		endcase
		return n;
	endfunction

	// Gate levels follow the half-bridge phase; peak on both edges
	function automatic hgs_gate_t gate_of(input hgs_hb_t hb);
		hgs_gate_t g;
		g.high_on = (hb.leg == LEG_HIGH);
		g.low_on = (hb.leg == LEG_LOW);
		g.peak = (hb.phase == HB_RAMP_OFF) || (hb.phase == HB_PEAK_ON);
		g.low_strong = (hb.phase == HB_PEAK_ON) && (hb.leg == LEG_HIGH);
		return g;
	endfunction

	hgs_deglitch #(
		.HOLD_CYC(GLITCH_CYC)
	) u_deglitch (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_d({i_bridge_in_a, i_bridge_in_b}),
		.o_q(filt)
	);

	// Command decode for both control styles, on filtered inputs only
	always_comb
	begin
		if (s.ctrl[CTRL_PWM_BIT])
		begin
			fwd = filt[1] && !filt[0];
			rev = !filt[1] && filt[0];
			brake_in = filt[1] && filt[0];
		end
		else
		begin
			fwd = filt[1] && filt[0];
			rev = filt[1] && !filt[0];
			brake_in = !filt[1];
		end
		drive_cmd = fwd || rev;
		reg_en = s.ctrl[CTRL_REG_EN_BIT] && !i_sense_grounded;
		oc_clear = i_bus.we && (i_bus.addr == REG_STATUS) && i_bus.wdata[ST_OC_BIT];
	end

	// Chopping, bridge targets, strap capture and register port
	always_comb
	begin
		next_s = s;
		next_s.prev_dir = fwd;
		case (s.chop)
			CH_IDLE:
			begin
				if (drive_cmd && reg_en)
				begin
					next_s.chop = CH_BLANK;
					next_s.cnt = BLANK_LAST;
				end
			end
			CH_BLANK:
			begin
				if (!drive_cmd || !reg_en)
					next_s.chop = CH_IDLE;
				else if (fwd != s.prev_dir)
					next_s.cnt = BLANK_LAST;
				else if (s.cnt == '0)
					next_s.chop = CH_ARMED;
				else
					next_s.cnt = s.cnt - 1'b1;
			end
			CH_ARMED:
			begin
				if (!drive_cmd || !reg_en)
					next_s.chop = CH_IDLE;
				else if (fwd != s.prev_dir)
				begin
					next_s.chop = CH_BLANK;
					next_s.cnt = BLANK_LAST;
				end
				else if (chop_current_threshold_over)
				begin
					next_s.chop = CH_OFF;
					next_s.cnt = OFF_LAST;
				end
			end
			CH_OFF:
			begin
				if (!drive_cmd || !reg_en)
					next_s.chop = CH_IDLE;
				else if (s.cnt == '0)
				begin
					next_s.chop = CH_BLANK;
					next_s.cnt = BLANK_LAST;
				end
				else
					next_s.cnt = s.cnt - 1'b1;
			end
			default: next_s.chop = CH_IDLE;
		endcase

		// Chop brake overrides the commanded drive on both low sides
		if (next_s.chop == CH_OFF)
		begin
			want_a = LEG_LOW;
			want_b = LEG_LOW;
		end
		else if (fwd)
		begin
			want_a = LEG_HIGH;
			want_b = LEG_LOW;
		end
		else if (rev)
		begin
			want_a = LEG_LOW;
			want_b = LEG_HIGH;
		end
		else if (brake_in)
		begin
			want_a = LEG_LOW;
			want_b = LEG_LOW;
		end
		else
		begin
			want_a = LEG_NONE;
			want_b = LEG_NONE;
		end
		next_s.hb_a = hb_step(s.hb_a, want_a);
		next_s.hb_b = hb_step(s.hb_b, want_b);
		next_s.gate_a = gate_of(next_s.hb_a);
		next_s.gate_b = gate_of(next_s.hb_b);

		// Pull the open-drain pin low only in the internal off-time
		next_s.chop_oe = (next_s.chop == CH_OFF);
		next_s.chop_o = 1'b0;

		// Set beats a clear that lands in the same cycle
		next_s.oc_level = i_sense_over;
		next_s.oc_sticky = (s.oc_sticky && !oc_clear) || i_sense_over;

		// Strap is caught once after wake and frozen until sleep
		if (!s.strap_loaded)
		begin
			next_s.strap = i_strap_code;
			next_s.drive = strap_decode(i_strap_code);
			next_s.strap_loaded = 1'b1;
		end

		if (i_bus.we && (i_bus.addr == REG_CTRL))
			next_s.ctrl = i_bus.wdata[1:0];
		next_s.rdata = '0;
		if (i_bus.re)
		begin
			case (i_bus.addr)
				REG_CTRL: next_s.rdata[1:0] = s.ctrl;
				REG_STATUS:
				begin
					next_s.rdata[ST_OC_BIT] = s.oc_sticky;
					next_s.rdata[ST_CHOP_BIT] = s.chop_oe;
					next_s.rdata[ST_HS_PROT_BIT] = s.drive.hs_prot_en;
					next_s.rdata[ST_STRAP_LSB +: 3] = s.strap;
				end
				default: next_s.rdata = '0;
			endcase
		end
	end

	// Reset values: bridge off, regulation on, strap not yet caught
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.strap <= STRAP_OPEN;
		end
		else
			s <= next_s;
	end

	assign o_gate_a = s.gate_a;
	assign o_gate_b = s.gate_b;
	assign o_drive = s.drive;
	assign o_chop_indicator_n_o = s.chop_o;
	assign o_chop_indicator_n_oe = s.chop_oe;
	assign o_overcurrent = s.oc_level;
	assign o_rdata = s.rdata;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_off_done;
		s.chop == CH_OFF && s.cnt == '0 && drive_cmd && reg_en;
	endsequence

	sequence s_high_falls;
		$fell(o_gate_a.high_on);
	endsequence

	a_chop_pull_cause: assert property ($rose(o_chop_indicator_n_oe) |->
		$past(s.chop) == CH_ARMED && $past(chop_current_threshold_over))
		else $error("chop indicator pulled without threshold hit");
	a_reg_off_release: assert property (!reg_en |=> !o_chop_indicator_n_oe)
		else $error("chop indicator pulled with regulation off");
	a_input_decay_quiet: assert property (!drive_cmd |=> !o_chop_indicator_n_oe)
		else $error("chop indicator pulled on commanded decay");
	a_off_end_resume: assert property (s_off_done |=>
		!o_chop_indicator_n_oe && s.chop == CH_BLANK)
		else $error("chop brake end did not release and resume");
	a_overcurrent_flag: assert property (i_sense_over |=> o_overcurrent && s.oc_sticky)
		else $error("overcurrent not flagged");
	a_strap_gnd_weak: assert property ($rose(s.strap_loaded) && s.strap == STRAP_GND |->
		o_drive.src == I_6MA && o_drive.snk == I_12P5MA && o_drive.hs_prot_en)
		else $error("grounded strap decoded wrong");
	a_strap_rail_mon: assert property ($rose(s.strap_loaded) && s.strap == STRAP_RAIL |->
		o_drive.src == I_25MA && !o_drive.hs_prot_en)
		else $error("rail strap decoded wrong");
	a_peak_then_hold: assert property ($rose(o_gate_a.high_on) |->
		o_gate_a.peak ##[1:1000] !o_gate_a.peak)
		else $error("peak drive did not fall to hold");
	a_low_strong_pull: assert property (o_gate_b.high_on && o_gate_b.peak |->
		o_gate_b.low_strong && !o_gate_b.low_on)
		else $error("low side not held strong during turn-on");
	a_no_cross_cond: assert property (!(o_gate_a.high_on && o_gate_a.low_on) &&
		!(o_gate_b.high_on && o_gate_b.low_on))
		else $error("both FETs of a half-bridge on");
	a_dead_gap_min: assert property (s_high_falls |-> (!o_gate_a.low_on) [*8])
		else $error("dead interval too short");
	a_blank_no_chop: assert property (s.chop == CH_BLANK |=> s.chop != CH_OFF)
		else $error("chop decided during blanking");
	a_strap_frozen: assert property (s.strap_loaded |=> $stable(o_drive))
		else $error("drive strength changed while active");
endmodule // hgs_sequencer

// ---- tb/hgs_bridge_model.sv ----
// Purpose: Model of the external FET bridge and motor winding.
// Assumes: Current rises while one diagonal conducts, decays otherwise.
// Notes: i_short forces both comparators high, like a shorted winding.
`timescale 1ns/1ps
module hgs_bridge_model
#(
	parameter int CHOP_LIM = 30,
	parameter int OC_LIM = 250
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire hgs_pkg::hgs_gate_t i_gate_a,
	input wire hgs_pkg::hgs_gate_t i_gate_b,
	input wire logic i_short,
	output logic o_chop_over,
	output logic o_sense_over,
	output logic o_shoot
);
	import hgs_pkg::*;
	logic drv;
	logic [7:0] cur;
	// A diagonal pair conducts; brake and coast let the current decay
	assign drv = (i_gate_a.high_on && i_gate_b.low_on) || (i_gate_b.high_on && i_gate_a.low_on);
	// Saturating current so a stalled motor never wraps to zero
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cur <= 8'h00;
		else if (drv && cur != 8'hff)
			cur <= cur + 8'h01;
		else if (!drv && cur != 8'h00)
			cur <= cur - 8'h01;
	end
	// Comparator levels and a leg overlap flag
	assign o_chop_over = i_short || (cur >= CHOP_LIM);
	assign o_sense_over = i_short || (cur >= OC_LIM);
	assign o_shoot = (i_gate_a.high_on && i_gate_a.low_on) || (i_gate_b.high_on && i_gate_b.low_on);
endmodule // hgs_bridge_model

// ---- tb/hgs_sequencer_tb_top.sv ----
// Purpose: Self-checking bench of the gate drive sequencer.
// Assumes: Counts shortened through the timing parameters.
// Notes: Read answers are checked from a queue of expected words.
`timescale 1ns/1ps
module hgs_sequencer_tb_top;
	import hgs_pkg::*;
	localparam int DRV_NS = 200;
	// Off-time must outlast a finishing turn-on plus a full retarget to the low side
	localparam int OFF_NS = 1500;
	localparam int BLK_NS = 200;
	localparam int GL_NS = 400;
	localparam int DRIVE_CYC = DRV_NS / CLK_NS;
	localparam int OFF_CYC = OFF_NS / CLK_NS;
	localparam int BLANK_CYC = BLK_NS / CLK_NS;
	localparam int GLITCH_CYC = GL_NS / CLK_NS;
	localparam int DEAD_CYC = DEAD_NS / CLK_NS;
	localparam int TIMEOUT = 20000;
	logic i_clk = 1'b0;
	logic arst_n = 1'b0;
	logic in_a = 1'b0;
	logic in_b = 1'b0;
	logic short = 1'b0;
	logic gnd = 1'b0;
	hgs_strap_t strap = STRAP_OPEN;
	hgs_bus_t bus = '0;
	hgs_gate_t ga;
	hgs_gate_t gb;
	hgs_drive_t drive;
	logic chop_o, chop_oe, oc, chop_ov, sense_ov, shoot, pin;
	logic [31:0] rdata;
	logic [31:0] r = 32'h0000_7534;
	logic [31:0] exp_q[$];
	logic re_q = 1'b0, up_q = 1'b0, so_q = 1'b0;
	logic [3:0] on_v, on_q = 4'h0;
	logic [2:0] gl;
	int offc[4] = '{100, 100, 100, 100};
	int miscompares = 0, comparisons = 0, cycles = 0, n, n_oe, n_hi;
	hgs_drive_t exp_drv[6] = '{'{I_6MA, I_12P5MA, 1'b1}, '{I_12P5MA, I_25MA, 1'b1},
		'{I_25MA, I_50MA, 1'b1}, '{I_100MA, I_200MA, 1'b1}, '{I_150MA, I_300MA, 1'b1},
		'{I_25MA, I_50MA, 1'b0}};
	// {two-input mode, a, b, high a, low a, high b, low b}
	logic [6:0] mt[7] = '{7'h05, 7'h39, 7'h26, 7'h40, 7'h69, 7'h56, 7'h75};
	logic [2:0] cf[3] = '{3'h2, 3'h4, 3'h7};

	always #(CLK_NS / 2) i_clk = ~i_clk;
	// Open-drain pin with its pull-up
	assign pin = chop_oe ? chop_o : 1'b1;
	assign on_v = {ga.high_on, ga.low_on, gb.high_on, gb.low_on};

	hgs_sequencer #(.T_DRIVE_NS(DRV_NS), .T_OFF_NS(OFF_NS), .T_BLANK_NS(BLK_NS),
		.T_GLITCH_NS(GL_NS)) u_hgs_sequencer (.i_clk(i_clk), .i_arst_n(arst_n),
		.i_bridge_in_a(in_a), .i_bridge_in_b(in_b), .chop_current_threshold_over(chop_ov),
		.i_sense_over(sense_ov), .i_sense_grounded(gnd), .i_strap_code(strap), .i_bus(bus),
		.o_gate_a(ga), .o_gate_b(gb), .o_drive(drive), .o_chop_indicator_n_o(chop_o),
		.o_chop_indicator_n_oe(chop_oe), .o_overcurrent(oc), .o_rdata(rdata));
	hgs_bridge_model u_hgs_bridge_model (.i_clk(i_clk), .i_arst_n(arst_n), .i_gate_a(ga),
		.i_gate_b(gb), .i_short(short), .o_chop_over(chop_ov), .o_sense_over(sense_ov),
		.o_shoot(shoot));

	// Helpers shared by all scenarios
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic sig(input int s);
		return s == 0 ? ga.high_on : chop_oe;
	endfunction
	task automatic summarize;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (exp !== got)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge i_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge i_clk);
		bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge i_clk);
		bus <= '0;
	endtask
	task automatic drive_in(input logic a, input logic b, input int len);
		@(posedge i_clk);
		in_a <= a;
		in_b <= b;
		repeat (len) @(posedge i_clk);
	endtask
	task automatic wait_sig(input int s, input int lim, output int k);
		k = 0;
		while (sig(s) !== 1'b1 && k < lim)
		begin
			@(negedge i_clk);
			k++;
		end
	endtask
	task automatic watch(input int len, output int k_oe, output int k_hi);
		k_oe = 0;
		k_hi = 0;
		repeat (len)
		begin
			@(negedge i_clk);
			k_oe += (chop_oe === 1'b1);
			k_hi += (ga.high_on === 1'b1);
		end
	endtask

	// Edge capture and the cycle ceiling that cuts a hang short
	always @(posedge i_clk)
	begin
		re_q <= bus.re;
		up_q <= arst_n;
		so_q <= sense_ov;
		cycles <= cycles + 1;
		if (cycles == TIMEOUT)
		begin
			miscompares++;
			summarize();
		end
	end
	// Read answers, overcurrent delay, leg overlap and dead time, mid-cycle
	always @(negedge i_clk)
	begin
		if (re_q)
			check("rdata", exp_q.pop_front(), rdata);
		if (up_q)
		begin
			check("overcurrent", so_q, oc);
			check("shoot", 1'b0, shoot);
			for (int i = 0; i < 4; i++)
			begin
				if (on_v[i] && !on_q[i])
					check("dead", 1'b1, offc[i ^ 1] >= DEAD_CYC);
				offc[i] = on_v[i] ? 0 : offc[i] + 1;
			end
			on_q = on_v;
		end
	end

	// Main sequence
	initial
	begin
		for (int c = 0; c < 6; c++)
		begin
			@(posedge i_clk);
			arst_n <= 1'b0;
			strap <= hgs_strap_t'(c);
			repeat (c == 0 ? 8 : 2) @(posedge i_clk);
			arst_n <= 1'b1;
			repeat (2) @(negedge i_clk);
			check("drive", exp_drv[c], drive);
			@(posedge i_clk);
			strap <= hgs_strap_t'(5 - c);
			repeat (5) @(negedge i_clk);
			check("drive_held", exp_drv[c], drive);
			rd(REG_STATUS, (32'(c) << ST_STRAP_LSB) | (32'(exp_drv[c].hs_prot_en) << 2));
		end
		rd(REG_CTRL, 32'h0000_0001);
		r = xs(r);
		wr(REG_CTRL, {r[31:2], 2'h0});
		rd(REG_CTRL, 32'h0000_0000);
		r = xs(r);
		wr(2'h2, r);
		rd(2'h2, 32'h0000_0000);
		rd(2'h3, 32'h0000_0000);
		// Short pulse, then a real forward command with peak and hold
		drive_in(1'b1, 1'b1, 20);
		in_a <= 1'b0;
		in_b <= 1'b0;
		watch(100, n_oe, n_hi);
		check("glitch", 0, n_hi);
		drive_in(1'b1, 1'b1, 0);
		wait_sig(0, 200, n);
		check("turn_on", 1'b1, n < 200);
		check("peak_on", 3'h6, {ga.peak, ga.low_strong, ga.low_on});
		n = 0;
		while (ga.peak === 1'b1 && n < 300)
		begin
			@(negedge i_clk);
			n++;
		end
		check("peak_len", DRIVE_CYC, n);
		check("hold", 2'h2, {ga.high_on, ga.peak});
		for (int i = 0; i < 7; i++)
		begin
			wr(REG_CTRL, {30'h0, mt[i][6], 1'b0});
			drive_in(mt[i][5], mt[i][4], 150);
			@(negedge i_clk);
			check("bridge", mt[i][3:0], on_v);
		end
		// Chopping forced by a shorted winding, blanking first
		wr(REG_CTRL, 32'h0000_0001);
		drive_in(1'b0, 1'b0, 150);
		short <= 1'b1;
		drive_in(1'b1, 1'b1, 0);
		watch(GLITCH_CYC + BLANK_CYC, n_oe, n_hi);
		check("blank", 0, n_oe);
		wait_sig(1, 20, n);
		check("chop_rise", 1'b1, n < 20);
		check("pin_low", 1'b0, pin);
		n = 0;
		while (chop_oe === 1'b1 && n < 200)
		begin
			gl = {ga.high_on, ga.low_on, gb.low_on};
			@(negedge i_clk);
			n++;
		end
		check("off_len", OFF_CYC, n);
		check("brake", 3'h3, gl);
		@(posedge i_clk);
		short <= 1'b0;
		wait_sig(0, 80, n);
		check("resume", 1'b1, n < 80);
		check("pin_rel", 1'b1, pin);
		wait_sig(1, 300, n);
		check("rechop", 1'b1, n < 300);
		drive_in(1'b0, 1'b1, 100);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge i_clk);
			in_a <= cf[i][2];
			gnd <= cf[i][0];
			short <= 1'b1;
			wr(REG_CTRL, {31'h0, cf[i][1]});
			watch(150, n_oe, n_hi);
			check("chop_idle", 0, n_oe);
		end
		@(posedge i_clk);
		short <= 1'b0;
		drive_in(1'b0, 1'b1, 300);
		rd(REG_STATUS, 32'h0000_0051);
		wr(REG_STATUS, 32'h0000_0001);
		rd(REG_STATUS, 32'h0000_0050);
		repeat (3) @(posedge i_clk);
		summarize();
	end
endmodule // hgs_sequencer_tb_top
